/* include/dbgtb_pkg.sv */
/*
  shared constants and carriers for the debug trace and breakpoint registers.
  assumes one system clock and a byte-wide cpu register port decoded to a 4-bit offset.
*/
package dbgtb_pkg;
  // cpu register offsets inside the debug page
  localparam logic [3:0] OFS_CMP_A_HI = 4'h0;
  localparam logic [3:0] OFS_CMP_A_LO = 4'h1;
  localparam logic [3:0] OFS_CMP_B_HI = 4'h2;
  localparam logic [3:0] OFS_CMP_B_LO = 4'h3;
  localparam logic [3:0] OFS_FIFO_HI = 4'h4;
  localparam logic [3:0] OFS_FIFO_LO = 4'h5;
  localparam logic [3:0] OFS_CTRL = 4'h6;
  localparam logic [3:0] OFS_TRIG = 4'h7;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_FRC = 4'hA;
  // debug_unit_control fields
  localparam int BIT_EN = 7;
  localparam int BIT_ARM = 6;
  localparam int BIT_TAG = 5;
  localparam int BIT_BRK = 4;
  localparam int BIT_RWA = 3;
  localparam int BIT_CMP_A_DIRECTION_ENABLE = 2;
  localparam int BIT_RWB = 1;
  localparam int BIT_CMP_B_DIRECTION_ENABLE = 0;
  // trigger, status and force reset fields
  localparam int BIT_BEGIN = 6;
  localparam int BIT_CAPTURE_RUN_FLAG = 5;
  localparam int BIT_FRC = 0;
  // reset values and trace sizes
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [15:0] BKPT_RST = 16'h0000;
  localparam int TRACE_DEPTH = 8;
  localparam int CNT_W = 4;
  // trigger modes
  localparam logic [3:0] MODE_A_ONLY = 4'h0;
  localparam logic [3:0] MODE_A_OR_B = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] MODE_EVT_B = 4'h3;
  localparam logic [3:0] MODE_A_EVT_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_B = 4'h5;
  localparam logic [3:0] MODE_A_NOT_B = 4'h6;
  localparam logic [3:0] MODE_INSIDE = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE = 4'h8;

  typedef enum logic [1:0] {
    BDC_NOP = 2'b00, BDC_READ_BREAKPOINT_CMD = 2'b01, BDC_WRITE_BREAKPOINT_CMD = 2'b10, BDC_WRITE_FRC = 2'b11
  } dbgtb_bdc_op_t;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00, RUN_WAIT = 2'b01, RUN_FILL = 2'b10, RUN_CIRC = 2'b11
  } dbgtb_run_t;

  typedef struct packed {
    logic [3:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } dbgtb_cpu_req_t;

  typedef struct packed {
    logic valid;
    logic fetch;
    logic rw;
    logic [15:0] addr;
    logic [7:0] data;
  } dbgtb_mon_t;

  typedef struct packed {
    dbgtb_bdc_op_t op;
    logic [15:0] data;
  } dbgtb_bdc_cmd_t;
endpackage : dbgtb_pkg

/* hw/dbgtb_top.sv */
/*
  debug trace, comparator and breakpoint register logic with its trace fifo.
  assumes cpu register strobes, bus monitor and serial debug commands all
  synchronous to clk; the serial protocol decoder lives outside.
*/
// Function
// - 16-bit breakpoint address reachable only by serial debug commands
// - breakpoint enabled and shaped by serial controller enable and force bits
// - force-reset register ignores cpu writes and reads back zero
// - serial write of one to bit 0 resets the whole chip
// - ten debug bytes sit in the cpu register map
// - comparator bytes reset to zero, always readable, writable only unarmed
// - fifo high window read-only, zero in event-only modes
// - reading fifo high window never advances the fifo
// - reading fifo low window advances when unarmed; read high byte first
// - event-only modes store one byte per entry in the low half
// - no advance on low reads while armed; read only after run
// - unarmed low read stores last fetched opcode address at tail
// - control register readable and writable at any time
// - bit 7 enables module, cannot be set while secured
// - bit 6 arms run; completion or clearing arm or enable stops it
// - bit 5 picks tag or force breaks, ignored without break enable
// - bit 4 breaks at trigger for end trace, at full for begin
// - bits 2 and 3 qualify comparator A by access direction
// - bits 0 and 1 qualify comparator B by access direction
// - run ends when full in begin trace or on trigger in end trace
// - breakpoint force mode breaks at boundary, tag mode tags fetched opcode
// - valid count clears at run start, reports 0 to 8, never decrements
`timescale 1ns/1ns

module dbgtb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_next

  // a full fifo still takes a word when the drain pops in the same cycle
  assign full = (cnt_q == DEPTH_C);
  assign out_valid = (cnt_q != '0);
  assign in_ready = !full || out_ready;
  assign out_data = mem[rd_q];

  // pointer and count next values
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? ptr_next(wr_q) : wr_q;
    rd_d = pop ? ptr_next(rd_q) : rd_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
    if (flush) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
  end

  // storage is not reset; only the pointers and the count say what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : dbgtb_fifo

module dbgtb_top import dbgtb_pkg::*; #(
  parameter int FIFO_DEPTH = TRACE_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // cpu register port
  input wire dbgtb_cpu_req_t cpu_req,
  output logic [7:0] cpu_rdata,
  // cpu bus monitor
  input wire dbgtb_mon_t mon,
  input wire logic mcu_secure,
  // serial debug controller side
  input wire dbgtb_bdc_cmd_t bdc_cmd,
  input wire logic breakpoint_enable,
  input wire logic breakpoint_force_select,
  output logic [15:0] bdc_rdata,
  output logic bdc_rvalid,
  // requests to the cpu and reset logic
  output logic bkpt_force_req,
  output logic bkpt_tag_req,
  output logic break_force_req,
  output logic break_tag_req,
  output logic mcu_reset_req
);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(FIFO_DEPTH);

  logic [15:0] cmp_a_q, cmp_a_d, cmp_b_q, cmp_b_d, bkpt_q, bkpt_d;
  logic [15:0] fetch_q, fetch_d, fifo_in, fifo_out;
  logic [7:0] ctrl_q, ctrl_d, trig_q, trig_d, rdata_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic af_q, af_d;
  dbgtb_run_t state_q, state_d;
  logic armed, evt_mode, hit_a, hit_b, trig, done;
  logic rd_lo, rd_hi, wr_ctrl, new_en, start;
  logic fifo_push, fifo_pop, fifo_flush, fifo_ready, fifo_valid, fifo_full;
  logic brk_d, bkf_d, bkt_d, rst_req_d, rvalid_d;
  logic [15:0] bdc_rdata_d;

  // address match with optional read/write qualification, rw high means read
  function automatic logic cmp_hit(input dbgtb_mon_t m, input logic [15:0] val,
                                   input logic dir_en, input logic dir_val);
    cmp_hit = m.valid && (m.addr == val) && (!dir_en || (m.rw == dir_val));
  endfunction : cmp_hit

  function automatic logic is_evt(input logic [3:0] mode);
    is_evt = (mode == MODE_EVT_B) || (mode == MODE_A_EVT_B);
  endfunction : is_evt

  dbgtb_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(fifo_flush),
    .in_valid(fifo_push),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out),
    .full(fifo_full)
  );

  // comparator and trigger decode
  always_comb begin
    armed = (state_q != RUN_IDLE);
    evt_mode = is_evt(trig_q[3:0]);
    hit_a = cmp_hit(mon, cmp_a_q, ctrl_q[BIT_CMP_A_DIRECTION_ENABLE], ctrl_q[BIT_RWA]);
    hit_b = cmp_hit(mon, cmp_b_q, ctrl_q[BIT_CMP_B_DIRECTION_ENABLE], ctrl_q[BIT_RWB]);
    case (trig_q[3:0])
      MODE_A_ONLY: trig = hit_a;
      MODE_A_OR_B: trig = hit_a || hit_b;
      MODE_A_THEN_B: trig = af_q && hit_b;
      MODE_EVT_B: trig = hit_b;
      MODE_A_EVT_B: trig = af_q && hit_b;
      MODE_A_AND_B: trig = hit_a && (mon.data == cmp_b_q[7:0]);
      MODE_A_NOT_B: trig = hit_a && (mon.data != cmp_b_q[7:0]);
      MODE_INSIDE: trig = mon.valid && (mon.addr >= cmp_a_q) && (mon.addr <= cmp_b_q);
      MODE_OUTSIDE: trig = mon.valid && ((mon.addr < cmp_a_q) || (mon.addr > cmp_b_q));
      default: trig = 1'b0;
    endcase
  end

  // cpu strobes: low read and control write have side effects, high read has none
  assign rd_lo = cpu_req.rd && (cpu_req.addr == OFS_FIFO_LO);
  assign rd_hi = cpu_req.rd && (cpu_req.addr == OFS_FIFO_HI);
  assign wr_ctrl = cpu_req.wr && (cpu_req.addr == OFS_CTRL);

  // run control, fifo feed and register next values
  always_comb begin
    cmp_a_d = cmp_a_q;
    cmp_b_d = cmp_b_q;
    ctrl_d = ctrl_q;
    trig_d = trig_q;
    state_d = state_q;
    af_d = af_q;
    cnt_d = cnt_q;
    fetch_d = (mon.valid && mon.fetch) ? mon.addr : fetch_q;
    new_en = cpu_req.wdata[BIT_EN] && !mcu_secure;
    start = 1'b0;
    done = 1'b0;
    brk_d = 1'b0;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    fifo_in = mon.addr;
    // comparator and trigger bytes are frozen while a run is armed
    if (cpu_req.wr && !armed) begin
      if (cpu_req.addr == OFS_CMP_A_HI) begin
        cmp_a_d[15:8] = cpu_req.wdata;
      end else if (cpu_req.addr == OFS_CMP_A_LO) begin
        cmp_a_d[7:0] = cpu_req.wdata;
      end else if (cpu_req.addr == OFS_CMP_B_HI) begin
        cmp_b_d[15:8] = cpu_req.wdata;
      end else if (cpu_req.addr == OFS_CMP_B_LO) begin
        cmp_b_d[7:0] = cpu_req.wdata;
      end else if (cpu_req.addr == OFS_TRIG) begin
        trig_d = cpu_req.wdata;
      end
    end
    // run state machine
    case (state_q)
      RUN_WAIT: begin
        if (trig) begin
          state_d = RUN_FILL;
          fifo_push = mon.fetch;
        end
      end
      RUN_FILL: begin
        if (fifo_full) begin
          done = 1'b1;
        end else if (evt_mode) begin
          fifo_in = {ZERO_BYTE, mon.data};
          fifo_push = trig;
        end else begin
          fifo_push = mon.valid && mon.fetch;
        end
      end
      RUN_CIRC: begin
        if (trig) begin
          done = 1'b1;
        end else begin
          fifo_push = mon.valid && mon.fetch;
          fifo_pop = fifo_push && fifo_full;
        end
      end
      default: begin
        // unarmed low read rotates the head out and the last fetch in
        if (rd_lo) begin
          fifo_pop = fifo_valid;
          fifo_push = 1'b1;
          fifo_in = fetch_q;
        end
      end
    endcase
    if (armed && hit_a) begin
      af_d = 1'b1;
    end
    if (armed && fifo_push && fifo_ready && (cnt_q != CNT_MAX)) begin
      cnt_d = cnt_q + CNT_W'(1);
    end
    // break at trigger for end traces, at fifo full for begin traces
    brk_d = ctrl_q[BIT_BRK] && done;
    if (done) begin
      state_d = RUN_IDLE;
    end
    // control register is never locked by the run
    if (wr_ctrl) begin
      ctrl_d = cpu_req.wdata;
      ctrl_d[BIT_EN] = new_en;
      ctrl_d[BIT_ARM] = cpu_req.wdata[BIT_ARM] && new_en;
      if (!ctrl_d[BIT_ARM]) begin
        state_d = RUN_IDLE;
      end else if (!armed) begin
        start = 1'b1;
        state_d = evt_mode ? RUN_FILL : (trig_q[BIT_BEGIN] ? RUN_WAIT : RUN_CIRC);
      end
    end
    if (done) begin
      ctrl_d[BIT_ARM] = 1'b0;
    end
    fifo_flush = start;
    if (start) begin
      cnt_d = '0;
      af_d = 1'b0;
      fifo_push = 1'b0;
      fifo_pop = 1'b0;
    end
  end

  // cpu read data, registered one cycle after the strobe
  always_comb begin
    rdata_d = ZERO_BYTE;
    if (cpu_req.addr == OFS_CMP_A_HI) begin
      rdata_d = cmp_a_q[15:8];
    end else if (cpu_req.addr == OFS_CMP_A_LO) begin
      rdata_d = cmp_a_q[7:0];
    end else if (cpu_req.addr == OFS_CMP_B_HI) begin
      rdata_d = cmp_b_q[15:8];
    end else if (cpu_req.addr == OFS_CMP_B_LO) begin
      rdata_d = cmp_b_q[7:0];
    end else if (cpu_req.addr == OFS_FIFO_HI) begin
      rdata_d = (evt_mode || !fifo_valid) ? ZERO_BYTE : fifo_out[15:8];
    end else if (cpu_req.addr == OFS_FIFO_LO) begin
      rdata_d = fifo_valid ? fifo_out[7:0] : ZERO_BYTE;
    end else if (cpu_req.addr == OFS_CTRL) begin
      rdata_d = ctrl_q;
    end else if (cpu_req.addr == OFS_TRIG) begin
      rdata_d = trig_q;
    end else if (cpu_req.addr == OFS_STAT) begin
      rdata_d = {af_q, 1'b0, armed, 1'b0, cnt_q};
    end else if (cpu_req.addr == OFS_FRC) begin
      rdata_d = ZERO_BYTE;
    end
    if (!cpu_req.rd) begin
      rdata_d = ZERO_BYTE;
    end
  end

  // serial debug commands and the breakpoint match
  always_comb begin
    bkpt_d = bkpt_q;
    bdc_rdata_d = bdc_rdata;
    rvalid_d = 1'b0;
    rst_req_d = 1'b0;
    if (bdc_cmd.op == BDC_WRITE_BREAKPOINT_CMD) begin
      bkpt_d = bdc_cmd.data;
    end else if (bdc_cmd.op == BDC_READ_BREAKPOINT_CMD) begin
      bdc_rdata_d = bkpt_q;
      rvalid_d = 1'b1;
    end else if (bdc_cmd.op == BDC_WRITE_FRC) begin
      rst_req_d = bdc_cmd.data[BIT_FRC];
    end
    // force needs no opcode; tag only marks a fetched opcode
    bkf_d = breakpoint_enable && breakpoint_force_select && cmp_hit(mon, bkpt_q, 1'b0, 1'b0);
    bkt_d = breakpoint_enable && !breakpoint_force_select && mon.fetch
            && cmp_hit(mon, bkpt_q, 1'b0, 1'b0);
  end

  // all state and outputs register here
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_a_q <= {CMP_RST, CMP_RST};
      cmp_b_q <= {CMP_RST, CMP_RST};
      ctrl_q <= CTRL_RST;
      trig_q <= TRIG_RST;
      state_q <= RUN_IDLE;
      af_q <= 1'b0;
      cnt_q <= '0;
      fetch_q <= BKPT_RST;
      bkpt_q <= BKPT_RST;
      cpu_rdata <= ZERO_BYTE;
      bdc_rdata <= BKPT_RST;
      bdc_rvalid <= 1'b0;
      break_force_req <= 1'b0;
      break_tag_req <= 1'b0;
      bkpt_force_req <= 1'b0;
      bkpt_tag_req <= 1'b0;
      mcu_reset_req <= 1'b0;
    end else begin
      cmp_a_q <= cmp_a_d;
      cmp_b_q <= cmp_b_d;
      ctrl_q <= ctrl_d;
      trig_q <= trig_d;
      state_q <= state_d;
      af_q <= af_d;
      cnt_q <= cnt_d;
      fetch_q <= fetch_d;
      bkpt_q <= bkpt_d;
      cpu_rdata <= rdata_d;
      bdc_rdata <= bdc_rdata_d;
      bdc_rvalid <= rvalid_d;
      break_force_req <= brk_d && !ctrl_q[BIT_TAG];
      break_tag_req <= brk_d && ctrl_q[BIT_TAG];
      bkpt_force_req <= bkf_d;
      bkpt_tag_req <= bkt_d;
      mcu_reset_req <= rst_req_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fifo_hi_hold: assert property (rd_hi && !armed |=> $stable(fifo_out) && $stable(cnt_q))
    else $error("high window read moved the fifo");
  a_armed_no_pop: assert property (rd_lo && armed && !fifo_push |=> $stable(fifo_out))
    else $error("armed low read advanced the fifo");
  a_cmp_lock: assert property (armed && cpu_req.wr && (cpu_req.addr == OFS_CMP_A_HI)
                               |=> $stable(cmp_a_q))
    else $error("comparator changed while armed");
  a_frc_zero: assert property (cpu_req.rd && (cpu_req.addr == OFS_FRC) |=> cpu_rdata == 8'h00)
    else $error("force reset register read non zero");
  a_force_reset: assert property ((bdc_cmd.op == BDC_WRITE_FRC) && bdc_cmd.data[0]
                                  |=> mcu_reset_req ##1 !mcu_reset_req)
    else $error("force reset not a single pulse");
  a_secure_en: assert property (wr_ctrl && mcu_secure |=> !ctrl_q[BIT_EN])
    else $error("enable set while secure");
  a_run_stop: assert property (armed && wr_ctrl && !cpu_req.wdata[BIT_ARM]
                               |=> (state_q == RUN_IDLE) && !ctrl_q[BIT_ARM])
    else $error("run kept going after disarm");
  a_cnt_bound: assert property ((state_q == RUN_FILL) && fifo_full
                                |=> (state_q == RUN_IDLE) && (cnt_q == 4'h8))
    else $error("begin trace did not end at eight words");
  a_end_break: assert property ((state_q == RUN_CIRC) && trig && ctrl_q[BIT_BRK] && !ctrl_q[BIT_TAG]
                                && !wr_ctrl |=> break_force_req)
    else $error("end trace break missing");
  a_bkpt_force: assert property (breakpoint_enable && breakpoint_force_select && mon.valid
                                 && (mon.addr == bkpt_q) |=> bkpt_force_req)
    else $error("forced breakpoint missed");

  c_begin_done: cover property ((state_q == RUN_FILL) ##1 (state_q == RUN_IDLE));
  c_end_done: cover property ((state_q == RUN_CIRC) && trig);
  c_profile: cover property (rd_lo && !armed && fifo_full);
endmodule : dbgtb_top

/* tb/dbgtb_cpu_model.sv */
/*
  cpu bus cycle source standing in for the core that the debug monitor watches.
  assumes the bench raises go for one cycle per bus cycle, just after a clock edge.
*/
`timescale 1ns/1ns
module dbgtb_cpu_model import dbgtb_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench request
  input wire logic go,
  input wire dbgtb_mon_t req,
  // monitor output
  output dbgtb_mon_t mon
);
  dbgtb_mon_t mon_q;
  dbgtb_mon_t mon_d;
  // idle cycles flip address and data so a stale value never passes for a live one
  always_comb begin
    mon_d = mon_q;
    if (go) begin
      mon_d = req;
      mon_d.valid = 1'b1;
    end else begin
      mon_d.valid = 1'b0;
      mon_d.addr = ~mon_q.addr;
      mon_d.data = ~mon_q.data;
    end
  end
  // registered, so a cycle shows one edge after its request
  always_ff @(posedge clk) begin
    if (rst) mon_q <= '0;
    else mon_q <= mon_d;
  end
  assign mon = mon_q;
endmodule : dbgtb_cpu_model

/* tb/dbgtb_tb_top.sv */
/*
  self-checking bench for the debug trace and breakpoint registers and the fifo.
  assumes the cpu model file and the design files are compiled first.
*/
`timescale 1ns/1ns
module dbgtb_tb_top import dbgtb_pkg::*; ;
  // wiring
  logic clk;
  logic rst;
  dbgtb_cpu_req_t cpu_req;
  logic [7:0] cpu_rdata;
  dbgtb_mon_t mon;
  dbgtb_mon_t mreq;
  logic go;
  logic mcu_secure;
  dbgtb_bdc_cmd_t bdc_cmd;
  logic bkpt_en;
  logic bkpt_fs;
  logic [15:0] bdc_rdata;
  logic bdc_rvalid;
  logic [4:0] req;
  // bench state
  logic [15:0] cnt [5];
  logic [31:0] seed = 32'h1cfd;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  dbgtb_top i_dut (.clk(clk), .rst(rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .mon(mon),
    .mcu_secure(mcu_secure), .bdc_cmd(bdc_cmd), .breakpoint_enable(bkpt_en),
    .breakpoint_force_select(bkpt_fs), .bdc_rdata(bdc_rdata), .bdc_rvalid(bdc_rvalid),
    .bkpt_force_req(req[0]), .bkpt_tag_req(req[1]), .break_force_req(req[2]),
    .break_tag_req(req[3]), .mcu_reset_req(req[4]));
  dbgtb_cpu_model i_cpu (.clk(clk), .rst(rst), .go(go), .req(mreq), .mon(mon));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // control readback: a secured part never shows the enable bit
  function automatic logic [7:0] ctrl_exp(input logic [7:0] w, input logic sec);
    ctrl_exp = w;
    if (sec) ctrl_exp[BIT_EN] = 1'b0;
  endfunction : ctrl_exp

  // break pulse expected per run: bit 0 force, bit 1 tag
  function automatic logic [1:0] brk_exp(input logic [7:0] c);
    if (!c[BIT_BRK]) return 2'b00;
    return c[BIT_TAG] ? 2'b10 : 2'b01;
  endfunction : brk_exp

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // each bus task leaves a spare cycle so no strobe is raised and dropped in one step
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    cpu_req.addr = a;
    cpu_req.rd = 1'b1;
    @(posedge clk); #1;
    cpu_req.rd = 1'b0;
    d = cpu_rdata;
    @(posedge clk); #1;
  endtask : rd

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check({8'h00, d}, {8'h00, e});
  endtask : chk_rd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cpu_req.addr = a;
    cpu_req.wdata = d;
    cpu_req.wr = 1'b1;
    @(posedge clk); #1;
    cpu_req.wr = 1'b0;
    @(posedge clk); #1;
  endtask : wr

  task automatic cyc(input logic [15:0] a, input logic rw, input logic fe, input logic [7:0] d);
    mreq.addr = a;
    mreq.rw = rw;
    mreq.fetch = fe;
    mreq.data = d;
    go = 1'b1;
    @(posedge clk); #1;
    go = 1'b0;
    @(posedge clk); #1;
  endtask : cyc

  task automatic bdc(input dbgtb_bdc_op_t op, input logic [15:0] d, output logic rv,
                     output logic [15:0] rdat);
    bdc_cmd.op = op;
    bdc_cmd.data = d;
    @(posedge clk); #1;
    bdc_cmd.op = BDC_NOP;
    rv = bdc_rvalid;
    rdat = bdc_rdata;
    @(posedge clk); #1;
  endtask : bdc

  // pulse counters and hang guard
  always @(posedge clk) begin
    cycles++;
    for (int j = 0; j < 5; j++) if (req[j] === 1'b1) cnt[j]++;
    if (cycles == 8000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    int i;
    int k;
    logic [31:0] r;
    logic [7:0] v;
    logic [7:0] s;
    logic [7:0] a1;
    logic [7:0] a2;
    logic [7:0] cmp [4];
    logic [7:0] d [8];
    logic [15:0] b;
    logic [15:0] rdat;
    logic [15:0] ef;
    logic [15:0] et;
    logic rv;
    logic [1:0] be;
    logic [15:0] w [8];
    for (i = 0; i < 5; i++) cnt[i] = 16'h0000;
    rst = 1'b1;
    cpu_req = '0;
    mreq = '0;
    go = 1'b0;
    mcu_secure = 1'b0;
    bdc_cmd = '0;
    bkpt_en = 1'b0;
    bkpt_fs = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk); #1;
    // reset values, unmapped offset, write-only force reset
    for (i = 0; i < 4; i++) chk_rd(4'(i), CMP_RST);
    chk_rd(OFS_CTRL, CTRL_RST);
    chk_rd(OFS_FRC, ZERO_BYTE);
    chk_rd(4'h9, ZERO_BYTE);
    // random comparator bytes and control values, secured and not
    for (i = 0; i < 8; i++) begin
      r = rnd();
      cmp[i % 4] = r[7:0];
      wr(4'(i % 4), r[7:0]);
      chk_rd(4'(i % 4), cmp[i % 4]);
      v = r[15:8] & 8'hBF;
      mcu_secure = r[16];
      wr(OFS_CTRL, v);
      chk_rd(OFS_CTRL, ctrl_exp(v, r[16]));
    end
    mcu_secure = 1'b0;
    wr(OFS_CTRL, 8'h00);
    // cpu cannot force reset, serial host can, only with bit 0 set
    wr(OFS_FRC, 8'h01);
    bdc(BDC_WRITE_FRC, 16'h0000, rv, rdat);
    bdc(BDC_WRITE_FRC, 16'h0001, rv, rdat);
    repeat (2) @(posedge clk);
    #1;
    check(cnt[4], 16'h0001);
    // breakpoint through serial commands, force then tag, then disabled
    r = rnd();
    bdc(BDC_WRITE_BREAKPOINT_CMD, r[15:0], rv, rdat);
    bdc(BDC_READ_BREAKPOINT_CMD, 16'h0000, rv, rdat);
    check(16'(rv), 16'h0001);
    check(rdat, r[15:0]);
    bkpt_en = 1'b1;
    bkpt_fs = 1'b1;
    cyc(r[15:0], 1'b1, 1'b1, 8'h00);
    bkpt_fs = 1'b0;
    cyc(r[15:0], 1'b1, 1'b1, 8'h00);
    cyc(~r[15:0], 1'b1, 1'b1, 8'h00);
    bkpt_en = 1'b0;
    cyc(r[15:0], 1'b1, 1'b1, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check(cnt[0], 16'h0001);
    check(cnt[1], 16'h0001);
    // event-only run on comparator B, write cycles only, read cycles interleaved
    b = r[31:16];
    wr(OFS_CMP_B_HI, b[15:8]);
    wr(OFS_CMP_B_LO, b[7:0]);
    wr(OFS_TRIG, {4'h0, MODE_EVT_B});
    wr(OFS_CTRL, 8'hC1);
    for (k = 0; k < 8; k++) begin
      r = rnd();
      d[k] = r[7:0];
      cyc(b, 1'b1, 1'b0, ~d[k]);
      if (k == 3) begin
        wr(OFS_CMP_A_HI, ~cmp[0]);
        rd(OFS_STAT, s);
        check(16'(s[BIT_CAPTURE_RUN_FLAG]), 16'h0001);
      end
      cyc(b, 1'b0, 1'b0, d[k]);
    end
    repeat (3) @(posedge clk);
    #1;
    rd(OFS_STAT, s);
    check(16'(s[BIT_CAPTURE_RUN_FLAG]), 16'h0000);
    check(16'(s[3:0]), 16'h0008);
    chk_rd(OFS_CMP_A_HI, cmp[0]);
    // readout, high first, then the profiling capture on the ninth low read
    r = rnd();
    cyc(r[15:0], 1'b1, 1'b1, 8'h00);
    wr(OFS_FIFO_LO, 8'hFF);
    wr(OFS_FIFO_HI, 8'hFF);
    for (k = 0; k < 8; k++) begin
      chk_rd(OFS_FIFO_HI, ZERO_BYTE);
      chk_rd(OFS_FIFO_LO, d[k]);
    end
    chk_rd(OFS_FIFO_LO, r[7:0]);
    rd(OFS_STAT, s);
    check(16'(s[3:0]), 16'h0008);
    // end trace that never triggers: two fetches stored, armed low reads hold, manual stop
    r = rnd();
    wr(OFS_TRIG, 8'h0F);
    wr(OFS_CTRL, 8'hC0);
    cyc(r[15:0], 1'b1, 1'b1, 8'h00);
    cyc({r[15:8], ~r[7:0]}, 1'b1, 1'b1, 8'h00);
    rd(OFS_FIFO_LO, a1);
    rd(OFS_FIFO_LO, a2);
    check(16'(a1), 16'(r[7:0]));
    check(16'(a2), 16'(a1));
    rd(OFS_STAT, s);
    check(16'(s[BIT_CAPTURE_RUN_FLAG]), 16'h0001);
    wr(OFS_CTRL, 8'h80);
    rd(OFS_STAT, s);
    check(16'(s[BIT_CAPTURE_RUN_FLAG]), 16'h0000);
    // end traces on comparator A, read cycles only, across break settings
    r = rnd();
    wr(OFS_CMP_A_HI, r[15:8]);
    wr(OFS_CMP_A_LO, r[7:0]);
    wr(OFS_TRIG, 8'h00);
    ef = cnt[2];
    et = cnt[3];
    for (k = 0; k < 3; k++) begin
      v = 8'hCC | (k != 2 ? 8'h10 : 8'h00) | (k != 0 ? 8'h20 : 8'h00);
      wr(OFS_CTRL, v);
      be = brk_exp(v);
      ef += 16'(be[0]);
      et += 16'(be[1]);
      cyc(r[15:0], 1'b0, 1'b0, 8'h00);
      rd(OFS_STAT, s);
      check(16'(s[BIT_CAPTURE_RUN_FLAG]), 16'h0001);
      cyc(r[15:0], 1'b1, 1'b0, 8'h00);
      repeat (4) @(posedge clk);
      #1;
      rd(OFS_STAT, s);
      check(16'(s[BIT_CAPTURE_RUN_FLAG]), 16'h0000);
      check(cnt[2], ef);
      check(cnt[3], et);
    end
    // begin trace: a comparator A fetch starts storage, eight fetches fill the fifo
    w[0] = r[15:0];
    for (k = 1; k < 8; k++) begin
      r = rnd();
      w[k] = r[15:0];
    end
    wr(OFS_TRIG, 8'h40);
    wr(OFS_CTRL, 8'hC0);
    for (k = 0; k < 8; k++) cyc(w[k], 1'b1, 1'b1, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    rd(OFS_STAT, s);
    check(16'(s[BIT_CAPTURE_RUN_FLAG]), 16'h0000);
    check(16'(s[3:0]), 16'h0008);
    for (k = 0; k < 8; k++) begin
      chk_rd(OFS_FIFO_HI, w[k][15:8]);
      chk_rd(OFS_FIFO_LO, w[k][7:0]);
    end
    conclude();
  end
endmodule : dbgtb_tb_top
